// ### logic/pwfr_unit.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pwfr_defines.svh"
module pwfr_unit (
   input wire logic clock,
   input wire logic rst,
   input wire pwfr_pkg::pwfr_req_s req,
   output pwfr_pkg::pwfr_rsp_s rsp,
   output logic [3:0] rsp_fault_code,
   input wire logic awvalid,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic [31:0] araddr,
   input wire logic rready,
   output pwfr_pkg::pwfr_axo_s axo
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      pwfr_pkg::pwfr_rsp_s rsp;
      logic [3:0] code;
      logic [7:0] dfs;
      logic [7:0] ffs;
      logic [31:0] fault_address;
      logic [3:0] ctrl;
      logic aw_got;
      logic w_got;
      logic [31:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      pwfr_pkg::pwfr_axo_s axo;
   } pwfr_state_s;
   pwfr_state_s state_reg;
   pwfr_state_s state_next;
   // ---------------------------------------------------------------
   // Walk and fault detection
   // ---------------------------------------------------------------
   logic [3:0] dom;
   logic [31:0] l2_addr;
   pwfr_pkg::pwfr_l2_e l2_kind;
   logic [1:0] sub_sel;
   logic [1:0] ap_acc;
   logic ap_same;
   logic f_align;
   logic f_trans;
   logic f_dom;
   logic f_perm;
   logic f_ext;
   logic perm_ok;
   logic [3:0] code;
   logic abort;
   logic en;
   always_comb begin
      en = state_reg.ctrl[`PWFR_CTRL_MMU_EN];
      dom = req.l1_desc[8:5];
      l2_kind = pwfr_pkg::pwfr_l2_e'(req.l2_desc[1:0]);
      // Table index drawn from the address; repeated entries make any copy
      // valid, so overlapping bits need no masking
      if (req.l1_fine) begin
         l2_addr = {req.l1_desc[31:12], req.modified_virtual_address[19:10], 2'h0};
      end else begin
         l2_addr = {req.l1_desc[31:10], req.modified_virtual_address[19:12], 2'h0};
      end
      // Subpage select: 16KB quarter for large, 1KB quarter for small
      if (l2_kind == pwfr_pkg::PWFR_L2_LARGE) begin
         sub_sel = req.modified_virtual_address[15:14];
      end else begin
         sub_sel = req.modified_virtual_address[11:10];
      end
      ap_same = (req.l2_desc[11:10] == req.l2_desc[9:8]) &&
         (req.l2_desc[9:8] == req.l2_desc[7:6]) &&
         (req.l2_desc[7:6] == req.l2_desc[5:4]);
      case (l2_kind)
         pwfr_pkg::PWFR_L2_TINY: ap_acc = req.l2_desc[5:4];
         default: ap_acc = req.l2_desc[4 + 2 * sub_sel +: 2];
      endcase
      case (ap_acc)
         2'h0: perm_ok = !req.is_write &&
            ((state_reg.ctrl[`PWFR_CTRL_S] && !req.user) ||
            state_reg.ctrl[`PWFR_CTRL_R]) &&
            !(state_reg.ctrl[`PWFR_CTRL_S] && state_reg.ctrl[`PWFR_CTRL_R]);
         2'h1: perm_ok = !req.user;
         2'h2: perm_ok = !req.user || !req.is_write;
         default: perm_ok = 1'b1;
      endcase
      f_align = state_reg.ctrl[`PWFR_CTRL_ALIGN_EN] && !req.is_fetch &&
         ((req.size == 2'(pwfr_pkg::PWFR_SZ_WORD) && req.modified_virtual_address[1:0] != 2'h0) ||
         (req.size == 2'(pwfr_pkg::PWFR_SZ_HALF) && req.modified_virtual_address[0]));
      f_trans = en && (req.l1_fault ||
         l2_kind == pwfr_pkg::PWFR_L2_FAULT ||
         (!req.l1_fine && l2_kind == pwfr_pkg::PWFR_L2_TINY));
      f_dom = en && (req.dom_ctrl == 2'h0 || req.dom_ctrl == 2'h2);
      f_perm = en && req.dom_ctrl == 2'h1 && !perm_ok;
      f_ext = req.ext_abort && (!req.is_fetch || !req.is_write);
      // Page codes, except the section translation code on l1_fault: section walks are outside this unit
      if (f_align) begin
         code = `PWFR_FC_ALIGN;
      end else if (f_trans) begin
         code = req.l1_fault ? `PWFR_FC_TRANS_SEC : `PWFR_FC_TRANS_PAGE;
      end else if (f_dom) begin
         code = `PWFR_FC_DOM_PAGE;
      end else if (f_perm) begin
         code = `PWFR_FC_PERM_PAGE;
      end else if (f_ext) begin
         code = `PWFR_FC_EXT_PAGE;
      end else begin
         code = 4'h0;
      end
      abort = f_align || f_trans || f_dom || f_perm || f_ext;
   end
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic wr_fire;
   logic [31:0] rd_val;
   always_comb begin
      state_next = state_reg;
      state_next.rsp.valid = req.valid;
      state_next.rsp.abort = req.valid && abort;
      state_next.rsp.bus_go = req.valid && !abort && !req.ext_abort;
      state_next.rsp.l2_addr = l2_addr;
      state_next.code = req.valid ? code : 4'h0;
      if (!en) begin
         state_next.rsp.phys = req.modified_virtual_address;
      end else begin
         case (l2_kind)
            pwfr_pkg::PWFR_L2_LARGE:
               state_next.rsp.phys = {req.l2_desc[31:16], req.modified_virtual_address[15:0]};
            pwfr_pkg::PWFR_L2_SMALL:
               state_next.rsp.phys = {req.l2_desc[31:12], req.modified_virtual_address[11:0]};
            default:
               state_next.rsp.phys = {req.l2_desc[31:10], req.modified_virtual_address[9:0]};
         endcase
      end
      state_next.rsp.tlb_load = req.valid && en && !abort;
      state_next.rsp.tlb_ap = ap_acc;
      state_next.rsp.tlb_base = state_next.rsp.phys;
      state_next.rsp.tlb_size = l2_kind;
      if (l2_kind != pwfr_pkg::PWFR_L2_TINY && !ap_same) begin
         // Only the accessed subpage enters the TLB
         state_next.rsp.tlb_size = 2'h0;
         if (l2_kind == pwfr_pkg::PWFR_L2_LARGE) begin
            state_next.rsp.tlb_base = {req.l2_desc[31:16], sub_sel, 14'h0};
         end else begin
            state_next.rsp.tlb_base = {req.l2_desc[31:12], sub_sel, 10'h0};
         end
      end else if (l2_kind == pwfr_pkg::PWFR_L2_LARGE) begin
         state_next.rsp.tlb_base = {req.l2_desc[31:16], 16'h0};
      end else if (l2_kind == pwfr_pkg::PWFR_L2_SMALL) begin
         state_next.rsp.tlb_base = {req.l2_desc[31:12], 12'h0};
      end else begin
         state_next.rsp.tlb_base = {req.l2_desc[31:10], 10'h0};
      end
      // AXI4-Lite write
      if (awvalid && state_reg.axo.awready) begin
         state_next.aw_got = 1'b1;
         state_next.aw_addr = awaddr;
      end
      if (wvalid && state_reg.axo.wready) begin
         state_next.w_got = 1'b1;
         state_next.w_data = wdata;
         state_next.w_strb = wstrb;
      end
      state_next.axo.awready = !state_next.aw_got && !state_reg.axo.bvalid;
      state_next.axo.wready = !state_next.w_got && !state_reg.axo.bvalid;
      wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.axo.bvalid;
      if (state_reg.axo.bvalid && bready) begin
         state_next.axo.bvalid = 1'b0;
         state_next.axo.awready = 1'b1;
         state_next.axo.wready = 1'b1;
      end
      if (wr_fire) begin
         state_next.aw_got = 1'b0;
         state_next.w_got = 1'b0;
         state_next.axo.bvalid = 1'b1;
         state_next.axo.bresp = `PWFR_RESP_OKAY;
         // Unmapped addresses steer to the error branch so nothing is written
         case ((state_reg.aw_addr[31:4] == 28'h0) ?
            state_reg.aw_addr[3:0] : 4'h1)
            `PWFR_OFF_DFS: if (state_reg.w_strb[0]) begin
               state_next.dfs = state_reg.w_data[7:0];
            end
            `PWFR_OFF_FFS: if (state_reg.w_strb[0]) begin
               state_next.ffs = state_reg.w_data[7:0];
            end
            `PWFR_OFF_FAR: begin
               for (int i = 0; i < 4; i++) begin
                  if (state_reg.w_strb[i]) begin
                     state_next.fault_address[8 * i +: 8] = state_reg.w_data[8 * i +: 8];
                  end
               end
            end
            `PWFR_OFF_CTRL: if (state_reg.w_strb[0]) begin
               state_next.ctrl = state_reg.w_data[3:0];
            end
            default: state_next.axo.bresp = `PWFR_RESP_SLVERR;
         endcase
         if (state_reg.aw_addr[31:4] != 28'h0) begin
            state_next.axo.bresp = `PWFR_RESP_SLVERR;
         end
      end
      // Fault capture overrides a software write in the same cycle
      if (req.valid && abort) begin
         if (req.is_fetch) begin
            state_next.ffs = {dom, code};
         end else begin
            state_next.dfs = {dom, code};
            state_next.fault_address = req.modified_virtual_address;
         end
      end
      // AXI4-Lite read
      case (araddr[3:0])
         `PWFR_OFF_DFS: rd_val = {24'h0, state_reg.dfs};
         `PWFR_OFF_FFS: rd_val = {24'h0, state_reg.ffs};
         `PWFR_OFF_FAR: rd_val = state_reg.fault_address;
         `PWFR_OFF_CTRL: rd_val = {28'h0, state_reg.ctrl};
         default: rd_val = 32'h0;
      endcase
      if (state_reg.axo.rvalid && rready) begin
         state_next.axo.rvalid = 1'b0;
         state_next.axo.arready = 1'b1;
      end
      if (arvalid && state_reg.axo.arready) begin
         state_next.axo.arready = 1'b0;
         state_next.axo.rvalid = 1'b1;
         state_next.axo.rdata = rd_val;
         state_next.axo.rresp = (araddr[31:4] == 28'h0 &&
            araddr[1:0] == 2'h0) ? `PWFR_RESP_OKAY : `PWFR_RESP_SLVERR;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.axo.awready <= 1'b1;
         state_reg.axo.wready <= 1'b1;
         state_reg.axo.arready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end
   assign rsp = state_reg.rsp;
   assign rsp_fault_code = state_reg.code;
   assign axo = state_reg.axo;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_abort_blocks_bus: assert property (@(posedge clock) disable iff (rst)
      rsp.abort |-> !rsp.bus_go) else $error("bus go on abort");
   a_align_first: assert property (@(posedge clock) disable iff (rst)
      req.valid && f_align |=> rsp_fault_code == 4'h1)
      else $error("alignment not first");
   a_no_fetch_align: assert property (@(posedge clock) disable iff (rst)
      req.valid && req.is_fetch && !f_trans && !f_dom && !f_perm && !f_ext
      |=> !rsp.abort) else $error("fetch aborted");
   a_mmu_off_quiet: assert property (@(posedge clock) disable iff (rst)
      req.valid && !en && !f_align && !req.ext_abort |=> !rsp.abort)
      else $error("fault while disabled");
   a_far_data_only: assert property (@(posedge clock) disable iff (rst)
      req.valid && abort && req.is_fetch && !(wr_fire &&
      state_reg.aw_addr[3:0] == `PWFR_OFF_FAR) |=> $stable(state_reg.fault_address))
      else $error("far moved on fetch");
   a_dfs_capture: assert property (@(posedge clock) disable iff (rst)
      req.valid && abort && !req.is_fetch |=>
      state_reg.dfs == {$past(dom), rsp_fault_code}) else $error("dfs");
   a_ffs_capture: assert property (@(posedge clock) disable iff (rst)
      req.valid && abort && req.is_fetch |=>
      state_reg.ffs[3:0] == rsp_fault_code) else $error("ffs");
   a_dom_none: assert property (@(posedge clock) disable iff (rst)
      req.valid && en && req.dom_ctrl == 2'h0 && !f_align && !f_trans
      |=> rsp_fault_code == 4'hB) else $error("domain none");
   a_hold_fault: assert property (@(posedge clock) disable iff (rst)
      !(req.valid && abort) && !wr_fire |=> $stable(state_reg.dfs))
      else $error("dfs drifted");
   c_perm_fault: cover property (@(posedge clock) rsp_fault_code == 4'hF);
   c_subpage: cover property (@(posedge clock)
      rsp.tlb_load && rsp.tlb_size == 2'h0);
   c_ext_abort: cover property (@(posedge clock) rsp_fault_code == 4'hA);
endmodule : pwfr_unit
`default_nettype wire

// ### logic/pwfr_defines.svh
`ifndef PWFR_DEFINES_SVH
`define PWFR_DEFINES_SVH
`define PWFR_OFF_DFS 4'h0
`define PWFR_OFF_FFS 4'h4
`define PWFR_OFF_FAR 4'h8
`define PWFR_OFF_CTRL 4'hC
`define PWFR_CTRL_MMU_EN 0
`define PWFR_CTRL_ALIGN_EN 1
`define PWFR_CTRL_S 2
`define PWFR_CTRL_R 3
`define PWFR_FC_ALIGN 4'h1
`define PWFR_FC_TRANS_SEC 4'h5
`define PWFR_FC_TRANS_PAGE 4'h7
`define PWFR_FC_DOM_SEC 4'h9
`define PWFR_FC_DOM_PAGE 4'hB
`define PWFR_FC_PERM_SEC 4'hD
`define PWFR_FC_PERM_PAGE 4'hF
`define PWFR_FC_EXT_SEC 4'h8
`define PWFR_FC_EXT_PAGE 4'hA
`define PWFR_RESP_OKAY 2'h0
`define PWFR_RESP_SLVERR 2'h2
`endif

// ### logic/pwfr_pkg.sv
package pwfr_pkg;
   typedef enum logic [1:0] {
      PWFR_L2_FAULT,
      PWFR_L2_LARGE,
      PWFR_L2_SMALL,
      PWFR_L2_TINY
   } pwfr_l2_e;
   typedef struct packed {
      logic valid;
      logic is_fetch;
      logic is_write;
      logic user;
      logic [1:0] size;
      logic [31:0] modified_virtual_address;
      logic l1_fault;
      logic l1_fine;
      logic [31:0] l1_desc;
      logic [31:0] l2_desc;
      logic [1:0] dom_ctrl;
      logic ext_abort;
   } pwfr_req_s;
   typedef struct packed {
      logic valid;
      logic abort;
      logic bus_go;
      logic [31:0] phys;
      logic tlb_load;
      logic [31:0] tlb_base;
      logic [1:0] tlb_size;
      logic [1:0] tlb_ap;
      logic [31:0] l2_addr;
   } pwfr_rsp_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pwfr_axo_s;
   typedef enum logic [1:0] {
      PWFR_SZ_BYTE,
      PWFR_SZ_HALF,
      PWFR_SZ_WORD
   } pwfr_size_e;
endpackage : pwfr_pkg

// ### testbench/pwfr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwfr_core_model (
   input wire logic clock,
   output var pwfr_pkg::pwfr_req_s req
);
   initial req = '0;
   // ---------------------------------------------------------------
   // Core requests and memory aborts
   // ---------------------------------------------------------------
   task automatic issue(input pwfr_pkg::pwfr_req_s want,
      output pwfr_pkg::pwfr_req_s sent);
      sent = want;
      // Memory aborts only where the core waits on it
      sent.ext_abort = want.ext_abort && (want.is_write ?
         !want.l2_desc[2] : !want.l2_desc[3]);
      @(posedge clock);
      req <= sent;
   endtask : issue
   // Released request lines carry garbage, not the last value
   task automatic idle();
      pwfr_pkg::pwfr_req_s junk;
      junk = ~req;
      junk.valid = 1'b0;
      req <= junk;
   endtask : idle
endmodule : pwfr_core_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwfr_defines.svh"
module tb_top;
   logic clock;
   logic rst;
   pwfr_pkg::pwfr_req_s req;
   pwfr_pkg::pwfr_rsp_s rsp;
   pwfr_pkg::pwfr_axo_s axo;
   logic [3:0] rsp_fault_code;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] awaddr, wdata, araddr;
   logic [3:0] wstrb;
   logic [31:0] ctrl, dfs_m, ffs_m, addr_m, rd;
   logic [1:0] resp;
   pwfr_pkg::pwfr_req_s r;
   int errors, checked, i;

   pwfr_unit uut (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
      .rsp_fault_code(rsp_fault_code), .awvalid(awvalid), .awaddr(awaddr),
      .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .bready(bready),
      .arvalid(arvalid), .araddr(araddr), .rready(rready), .axo(axo));
   pwfr_core_model core (.clock(clock), .req(req));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #100000;
      errors++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] want,
      input string what);
      checked++;
      if (got !== want) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
            want);
      end
   endtask : chk
   task automatic axi(input bit wr, input logic [31:0] addr,
      input logic [31:0] data, output logic [31:0] got,
      output logic [1:0] code);
      int n;
      pwfr_pkg::pwfr_axo_s seen;
      n = 0;
      got = '0;
      code = 2'h3;
      @(posedge clock);
      if (wr) begin
         awaddr <= addr;
         wdata <= data;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= addr;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      while (n < 40) begin
         // Slave outputs are registered: the mid-cycle value is what the
         // coming rising edge samples, free of the edge race
         @(negedge clock);
         seen = axo;
         @(posedge clock);
         n++;
         if (awvalid && seen.awready) awvalid <= 1'b0;
         if (wvalid && seen.wready) wvalid <= 1'b0;
         if (arvalid && seen.arready) arvalid <= 1'b0;
         if ((bready && seen.bvalid) || (rready && seen.rvalid)) begin
            code = wr ? seen.bresp : seen.rresp;
            got = seen.rdata;
            bready <= 1'b0;
            rready <= 1'b0;
            n = 99;
         end
      end
      if (n != 99) chk(32'h0, 32'h1, "bus hang");
   endtask : axi
   task automatic rchk(input logic [3:0] off, input logic [31:0] want);
      axi(1'b0, {28'h0, off}, 32'h0, rd, resp);
      chk(32'(resp), 32'(`PWFR_RESP_OKAY), "read resp");
      chk(rd, want, "register");
   endtask : rchk
   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic void predict(input pwfr_pkg::pwfr_req_s s,
      output int code, output logic [1:0] perm, output logic [1:0] ts,
      output logic [31:0] pa, output logic [31:0] la);
      logic [1:0] t;
      logic [1:0] sub;
      bit ok;
      t = s.l2_desc[1:0];
      sub = (t == 2'h1) ? s.modified_virtual_address[15:14] : s.modified_virtual_address[11:10];
      perm = (t == 2'h3) ? s.l2_desc[5:4] : s.l2_desc[4 + 2 * sub +: 2];
      ts = (t == 2'h3 || s.l2_desc[11:4] == {4{perm}}) ? t : 2'h0;
      pa = (t == 2'h1) ? {s.l2_desc[31:16], s.modified_virtual_address[15:0]} : (t == 2'h2) ?
         {s.l2_desc[31:12], s.modified_virtual_address[11:0]} : {s.l2_desc[31:10], s.modified_virtual_address[9:0]};
      la = s.l1_fine ? {s.l1_desc[31:12], s.modified_virtual_address[19:10], 2'h0} :
         {s.l1_desc[31:10], s.modified_virtual_address[19:12], 2'h0};
      case (perm)
         2'h0: ok = !s.is_write && ((ctrl[2] && !s.user) || ctrl[3]);
         2'h1: ok = !s.user;
         2'h2: ok = !s.user || !s.is_write;
         default: ok = 1'b1;
      endcase
      code = s.ext_abort ? 32'hA : 32'h0;
      if (ctrl[0] && s.dom_ctrl == 2'h1 && !ok) code = 32'hF;
      if (ctrl[0] && !s.dom_ctrl[0]) code = 32'hB;
      if (ctrl[0] && t == 2'h0) code = 32'h7;
      if (ctrl[0] && s.l1_fault) code = 32'h5;
      if (ctrl[1] && !s.is_fetch && ((s.size == 2'h2 && s.modified_virtual_address[1:0] != 2'h0)
         || (s.size == 2'h1 && s.modified_virtual_address[0]))) code = 32'h1;
   endfunction : predict
   task automatic xlate(input pwfr_pkg::pwfr_req_s want);
      pwfr_pkg::pwfr_req_s s;
      int code;
      logic [1:0] perm, ts;
      logic [31:0] pa, la, base;
      core.issue(want, s);
      predict(s, code, perm, ts, pa, la);
      @(posedge clock);
      core.idle();
      #1;
      chk(32'(rsp.valid), 32'h1, "rsp valid");
      chk(32'(rsp_fault_code), 32'(code), "fault code");
      chk(32'(rsp.abort), 32'(code != 0), "abort");
      chk(32'(rsp.bus_go), 32'(code == 0 && !s.ext_abort), "bus go");
      if (ctrl[0] && !s.l1_fault) chk(rsp.l2_addr, la, "walk");
      if (ctrl[0] && code == 0) begin
         chk(rsp.phys, pa, "phys");
         chk(32'({rsp.tlb_load, rsp.tlb_size, rsp.tlb_ap}),
            32'({1'b1, ts, perm}), "tlb");
         base = (s.l2_desc[1:0] == 2'h1) ? {pa[31:16], 16'h0} :
            (s.l2_desc[1:0] == 2'h2) ? {pa[31:12], 12'h0} :
            {pa[31:10], 10'h0};
         // Subpage entries are separate TLB entries, based on the subpage
         if (ts == 2'h0) base = (s.l2_desc[1:0] == 2'h1) ?
            {pa[31:14], 14'h0} : {pa[31:10], 10'h0};
         chk(rsp.tlb_base, base, "tlb base");
      end
      if (code != 0 && s.is_fetch) ffs_m = {24'h0, s.l1_desc[8:5], 4'(code)};
      if (code != 0 && !s.is_fetch) begin
         dfs_m = {24'h0, s.l1_desc[8:5], 4'(code)};
         addr_m = s.modified_virtual_address;
      end
      rchk(`PWFR_OFF_DFS, dfs_m);
      rchk(`PWFR_OFF_FFS, ffs_m);
      rchk(`PWFR_OFF_FAR, addr_m);
   endtask : xlate
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      errors = 0;
      checked = 0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'hF;
      {ctrl, dfs_m, ffs_m, addr_m} = '0;
      void'($urandom(34030));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk(32'({axo.awready, axo.wready, axo.arready, axo.bvalid, axo.rvalid}),
         32'h1C, "idle bus");
      for (i = 0; i < 16; i += 4) rchk(4'(i), 32'h0);
      axi(1'b1, 32'h0, 32'h5A, rd, resp);
      chk(32'(resp), 32'(`PWFR_RESP_OKAY), "write resp");
      dfs_m = 32'h5A;
      axi(1'b1, 32'h10, 32'h7, rd, resp);
      chk(32'(resp), 32'(`PWFR_RESP_SLVERR), "unmapped write");
      axi(1'b0, 32'h10, 32'h0, rd, resp);
      chk(32'(resp), 32'(`PWFR_RESP_SLVERR), "unmapped read");
      rchk(`PWFR_OFF_DFS, dfs_m);
      for (i = 0; i < 320; i++) begin
         if (i % 40 == 0) begin
            // Cycles both enables; S and R never set together
            ctrl = 32'((i / 40) % 4 + 4 * $urandom_range(2));
            axi(1'b1, {28'h0, `PWFR_OFF_CTRL}, ctrl, rd, resp);
            rchk(`PWFR_OFF_CTRL, ctrl);
         end
         r = $bits(r)'({$urandom, $urandom, $urandom, $urandom});
         r.valid = 1'b1;
         r.size = 2'($urandom_range(2));
         r.is_write = r.is_write && !r.is_fetch;
         r.l1_fault = ($urandom_range(7) == 0);
         r.ext_abort = r.ext_abort && ctrl[0];
         if (!r.l1_fine && r.l2_desc[1:0] == 2'h3) r.l2_desc[1] = 1'b0;
         if (r.l2_desc[12]) r.l2_desc[11:4] = {4{r.l2_desc[5:4]}};
         if (r.l2_desc[13]) r.modified_virtual_address[1:0] = 2'h0;
         xlate(r);
      end
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
